// File: core/dagm_ea_calc.sv
// Purpose: one effective-address path with modulo and bit-reversed correction
// Assumes: purely combinational, fed from the top each cycle
// Notes:   buffers hold word data; length is end minus start plus one word
`timescale 1ns/1ps
module dagm_ea_calc (
	input  wire dagm_pkg::dagm_op_t  op_i,
	input  wire logic [15:0]         off_i,
	input  wire logic                mac_i,
	input  wire logic                byte_i,
	input  wire dagm_pkg::dagm_cfg_t cfg_i,
	output dagm_pkg::dagm_res_t      res_o
);
	function automatic logic [15:0] rev16(input logic [15:0] a);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[i] = a[15-i];
		end
		return r;
	endfunction : rev16

	dagm_pkg::dagm_unit_t unit;
	logic        pre, post, mac_ok, brev_on, x_on, y_on, pow2, up;
	logic [15:0] mod, sum, bsum, lo, hi, len, corr, fix;

	always_comb begin
		// mac operands: low pair on x read, high pair on y
		unit = mac_i ? (op_i.ptr_sel[1] ? dagm_pkg::DAGM_U_Y
			: dagm_pkg::DAGM_U_XRD) : op_i.unit;
		pre  = op_i.mode == dagm_pkg::DAGM_AM_PRE;
		post = op_i.mode == dagm_pkg::DAGM_AM_POST;
		mac_ok = (op_i.ptr_sel[3:2] == dagm_pkg::MAC_GRP) &&
			((op_i.mode == dagm_pkg::DAGM_AM_IND) ||
			(post && (op_i.step == dagm_pkg::STEP2 || op_i.step == dagm_pkg::STEP4 ||
			op_i.step == dagm_pkg::STEP6 || op_i.step == -dagm_pkg::STEP2 ||
			op_i.step == -dagm_pkg::STEP4 || op_i.step == -dagm_pkg::STEP6)) ||
			(op_i.mode == dagm_pkg::DAGM_AM_REGOFF && op_i.ptr_sel[0]));
		// shared offset register value for indexed mode
		mod = (op_i.mode == dagm_pkg::DAGM_AM_REGOFF) ? off_i :
			(pre || post || op_i.mode == dagm_pkg::DAGM_AM_LITOFF) ? op_i.step : '0;
		sum = op_i.ptr_val + mod;
		// pointer and modifier are both reversed, added, and the sum reversed back
		bsum = rev16(rev16(op_i.ptr_val) + rev16({cfg_i.brev[14:0], 1'b0}));
		bsum[0] = 1'b0;
		brev_on = unit == dagm_pkg::DAGM_U_XWR && cfg_i.brev[dagm_pkg::BREN_BIT] &&
			cfg_i.mode[dagm_pkg::BSEL_LSB +: 4] != dagm_pkg::SEL_NONE &&
			op_i.ptr_sel == cfg_i.mode[dagm_pkg::BSEL_LSB +: 4] &&
			(pre || post) && !op_i.step[15] && !byte_i;
		x_on = unit != dagm_pkg::DAGM_U_Y && cfg_i.mode[dagm_pkg::XEN_BIT] &&
			cfg_i.mode[dagm_pkg::XSEL_LSB +: 4] != dagm_pkg::SEL_NONE &&
			op_i.ptr_sel == cfg_i.mode[dagm_pkg::XSEL_LSB +: 4] && !brev_on;
		y_on = unit == dagm_pkg::DAGM_U_Y && cfg_i.mode[dagm_pkg::YEN_BIT] &&
			cfg_i.mode[dagm_pkg::YSEL_LSB +: 4] != dagm_pkg::SEL_NONE &&
			op_i.ptr_sel == cfg_i.mode[dagm_pkg::YSEL_LSB +: 4];
		lo   = y_on ? cfg_i.ystart : cfg_i.xstart;
		hi   = y_on ? cfg_i.yend : cfg_i.xend;
		len  = hi - lo + dagm_pkg::WORD_ADJ;
		pow2 = (len & (len - 16'h0001)) == 16'h0000;
		up   = !mod[15];
		// ordered compares catch steps that jump past a boundary
		if ((up || pow2) && sum > hi) begin
			corr = sum - len;
		end else if ((!up || pow2) && sum < lo) begin
			corr = sum + len;
		end else begin
			corr = sum;
		end
		if (y_on) begin
			corr[0] = 1'b0;
		end
		fix = brev_on ? bsum : (x_on || y_on) ? corr : sum;
		res_o.ea = (pre || op_i.mode == dagm_pkg::DAGM_AM_REGOFF ||
			op_i.mode == dagm_pkg::DAGM_AM_LITOFF) ? fix : op_i.ptr_val;
		res_o.invalid = op_i.valid && mac_i && !mac_ok;
		res_o.wb_en   = op_i.valid && (pre || post) && !res_o.invalid;
		res_o.wb_val  = fix;
		res_o.xmod    = op_i.valid && x_on && mod != 16'h0000;
		res_o.ymod    = op_i.valid && y_on && mod != 16'h0000;
		res_o.brev    = op_i.valid && brev_on;
	end
endmodule : dagm_ea_calc

// File: core/dagm_top.sv
// Purpose: address generation unit with circular buffers and apb registers
// Assumes: decoder requests are on sys_clk_i; apb master on the same clock
// Notes:   results appear one cycle after a request
`timescale 1ns/1ps
module dagm_top (
	input  wire logic                sys_clk_i,
	input  wire logic                resetn_i,
	input  wire logic [11:0]         paddr_i,
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [31:0]         pwdata_i,
	input  wire logic [3:0]          pstrb_i,
	output logic [31:0]              prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	input  wire logic                req_valid_i,
	input  wire dagm_pkg::dagm_req_t req_i,
	output dagm_pkg::dagm_res_t      src_res_o,
	output dagm_pkg::dagm_res_t      dst_res_o,
	output logic [31:0]              lit_ext_o,
	output logic                     done_o
);
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ------------------------------------------------------------
	// register decode helpers
	// ------------------------------------------------------------
	function automatic logic reg_hit(input logic [11:0] a);
		return a == dagm_pkg::OFF_MODE || a == dagm_pkg::OFF_XSTART ||
			a == dagm_pkg::OFF_XEND || a == dagm_pkg::OFF_YSTART ||
			a == dagm_pkg::OFF_YEND || a == dagm_pkg::OFF_BREV ||
			a == dagm_pkg::OFF_STAT;
	endfunction : reg_hit

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : merge

	// ------------------------------------------------------------
	// address paths
	// ------------------------------------------------------------
	dagm_pkg::dagm_state_t st_r;
	dagm_pkg::dagm_state_t st_nxt;
	dagm_pkg::dagm_res_t   res_w [2];

	for (genvar g = 0; g < 2; g++) begin : g_path
		dagm_ea_calc u_calc (
			.op_i   (req_i.op[g]),
			.off_i  (req_i.off_val),
			.mac_i  (req_i.mac),
			.byte_i (req_i.byte_acc),
			.cfg_i  (st_r.cfg),
			.res_o  (res_w[g])
		);
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic        wr_acc;
	logic [15:0] rd16;

	always_comb begin
		st_nxt         = st_r;
		st_nxt.pready  = 1'b0;
		st_nxt.pslverr = 1'b0;
		st_nxt.done    = req_valid_i;
		wr_acc = psel_i && penable_i && st_r.pready && pwrite_i && !st_r.pslverr;
		case (paddr_i)
			dagm_pkg::OFF_MODE:   rd16 = st_r.cfg.mode;
			dagm_pkg::OFF_XSTART: rd16 = st_r.cfg.xstart;
			dagm_pkg::OFF_XEND:   rd16 = st_r.cfg.xend;
			dagm_pkg::OFF_YSTART: rd16 = st_r.cfg.ystart;
			dagm_pkg::OFF_YEND:   rd16 = st_r.cfg.yend;
			dagm_pkg::OFF_BREV:   rd16 = st_r.cfg.brev;
			dagm_pkg::OFF_STAT:   rd16 = {11'h000, st_r.stat};
			default:              rd16 = 16'h0000;
		endcase
		// setup phase: answer is ready for the access phase
		if (psel_i && !penable_i) begin
			st_nxt.pready  = 1'b1;
			st_nxt.pslverr = !reg_hit(paddr_i);
			st_nxt.prdata  = {16'h0000, rd16};
		end
		if (wr_acc) begin
			case (paddr_i)
				dagm_pkg::OFF_MODE:
					st_nxt.cfg.mode = merge(st_r.cfg.mode, pwdata_i, pstrb_i);
				dagm_pkg::OFF_XSTART:
					st_nxt.cfg.xstart = merge(st_r.cfg.xstart, pwdata_i, pstrb_i);
				dagm_pkg::OFF_XEND:
					st_nxt.cfg.xend = merge(st_r.cfg.xend, pwdata_i, pstrb_i);
				dagm_pkg::OFF_YSTART:
					st_nxt.cfg.ystart = merge(st_r.cfg.ystart, pwdata_i, pstrb_i);
				dagm_pkg::OFF_YEND:
					st_nxt.cfg.yend = merge(st_r.cfg.yend, pwdata_i, pstrb_i);
				dagm_pkg::OFF_BREV:
					st_nxt.cfg.brev = merge(st_r.cfg.brev, pwdata_i, pstrb_i);
				dagm_pkg::OFF_STAT:
					if (pstrb_i[0]) begin
						st_nxt.stat = st_r.stat & ~pwdata_i[4:0];
					end
				default: begin
				end
			endcase
		end
		// sticky events set after the clear so that set wins
		if (req_valid_i) begin
			st_nxt.src = res_w[0];
			st_nxt.dst = res_w[1];
			// branch literal signed, disable count unsigned
			st_nxt.lit = req_i.lit_interrupt_disable_instruction ?
				{{(32-dagm_pkg::INTERRUPT_DISABLE_INSTRUCTION_W){1'b0}}, req_i.lit[dagm_pkg::INTERRUPT_DISABLE_INSTRUCTION_W-1:0]} :
				{{16{req_i.lit[15]}}, req_i.lit};
			if (res_w[0].xmod || res_w[1].xmod) begin
				st_nxt.stat[dagm_pkg::ST_XMOD] = 1'b1;
			end
			if (res_w[0].ymod || res_w[1].ymod) begin
				st_nxt.stat[dagm_pkg::ST_YMOD] = 1'b1;
			end
			if (res_w[0].brev || res_w[1].brev) begin
				st_nxt.stat[dagm_pkg::ST_BREV] = 1'b1;
			end
			if (res_w[0].invalid || res_w[1].invalid) begin
				st_nxt.stat[dagm_pkg::ST_MACERR] = 1'b1;
			end
		end else begin
			st_nxt.src = '0;
			st_nxt.dst = '0;
		end
		// reversed buffer bounds give no valid length
		if (st_r.cfg.xend < st_r.cfg.xstart || st_r.cfg.yend < st_r.cfg.ystart) begin
			st_nxt.stat[dagm_pkg::ST_CFGERR] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r            <= '0;
			st_r.cfg.mode   <= dagm_pkg::MODE_RST;
			st_r.cfg.xstart <= dagm_pkg::ADDR_RST;
			st_r.cfg.xend   <= dagm_pkg::ADDR_RST;
			st_r.cfg.ystart <= dagm_pkg::ADDR_RST;
			st_r.cfg.yend   <= dagm_pkg::ADDR_RST;
			st_r.cfg.brev   <= dagm_pkg::BREV_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata_o  = st_r.prdata;
	assign pready_o  = st_r.pready;
	assign pslverr_o = st_r.pslverr;
	assign src_res_o = st_r.src;
	assign dst_res_o = st_r.dst;
	assign lit_ext_o = st_r.lit;
	assign done_o    = st_r.done;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n);

	sequence s_pre_req;
		req_valid_i && req_i.op[0].valid && !req_i.mac &&
		req_i.op[0].mode == dagm_pkg::DAGM_AM_PRE;
	endsequence
	sequence s_pre_wb;
		done_o && src_res_o.wb_en && src_res_o.wb_val == src_res_o.ea;
	endsequence
	sequence s_idx_req;
		req_valid_i && req_i.op[0].valid &&
		req_i.op[0].mode == dagm_pkg::DAGM_AM_REGOFF;
	endsequence

	a_pre_writeback: assert property (s_pre_req |=> s_pre_wb)
		else $error("pre-modify result not written back");
	a_index_keeps: assert property (s_idx_req |=> !src_res_o.wb_en)
		else $error("indexed mode wrote pointer back");
	a_mac_range: assert property (req_valid_i && req_i.mac && req_i.op[0].valid &&
		req_i.op[0].ptr_sel[3:2] != dagm_pkg::MAC_GRP |=> src_res_o.invalid)
		else $error("mac pointer outside W8..W11 accepted");
	a_mac_index: assert property (s_idx_req and (req_i.mac &&
		req_i.op[0].ptr_sel == 4'h8) |=> src_res_o.invalid)
		else $error("mac indexed mode accepted on W8");
	a_interrupt_disable_instruction_lit: assert property (req_valid_i && req_i.lit_interrupt_disable_instruction |=>
		lit_ext_o == {18'h0, $past(req_i.lit[13:0])})
		else $error("disable literal not zero extended");
	a_branch_lit: assert property (req_valid_i && !req_i.lit_interrupt_disable_instruction |=>
		lit_ext_o[31:15] == {17{$past(req_i.lit[15])}})
		else $error("branch literal not sign extended");
	a_xsel_off: assert property ($past(st_r.cfg.mode[3:0]) == dagm_pkg::SEL_NONE |->
		!src_res_o.xmod && !dst_res_o.xmod)
		else $error("x modulo active with select 15");
	a_xen_off: assert property (!$past(st_r.cfg.mode[15]) |->
		!src_res_o.xmod && !dst_res_o.xmod)
		else $error("x modulo active while disabled");
	a_yen_off: assert property (!$past(st_r.cfg.mode[14]) ||
		$past(st_r.cfg.mode[7:4]) == dagm_pkg::SEL_NONE |-> !src_res_o.ymod)
		else $error("y modulo active while disabled");
	a_y_word: assert property (src_res_o.ymod |-> !src_res_o.wb_val[0])
		else $error("y modulo address odd");
	a_x_bounds: assert property (src_res_o.xmod && src_res_o.wb_en &&
		$past(st_r.cfg.xstart) <= $past(st_r.cfg.xend) &&
		$past(req_i.op[0].ptr_val) >= $past(st_r.cfg.xstart) &&
		$past(req_i.op[0].ptr_val) <= $past(st_r.cfg.xend) &&
		$past(req_i.op[0].step) == dagm_pkg::STEP2 |->
		src_res_o.wb_val >= $past(st_r.cfg.xstart) &&
		src_res_o.wb_val <= $past(st_r.cfg.xend))
		else $error("x modulo result left the buffer");
	a_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
		else $error("register access not answered");
endmodule : dagm_top

// File: dv/dagm_dec_model.sv
// Purpose: behavioural decoder that hands address requests to the unit
// Assumes: one request per go pulse, presented for exactly one cycle
// Notes:   between requests the lines toggle so stale values never look valid
`timescale 1ns/1ps
module dagm_dec_model (
	input  wire logic                sys_clk_i,
	input  wire logic                resetn_i,
	input  wire logic                go_i,
	input  wire dagm_pkg::dagm_req_t cmd_i,
	output logic                     req_valid_o,
	output dagm_pkg::dagm_req_t      req_o
);
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			req_valid_o <= 1'b0;
			req_o       <= '0;
		end else if (go_i) begin
			req_valid_o <= 1'b1;
			req_o       <= cmd_i;
		end else begin
			req_valid_o <= 1'b0;
			req_o       <= ~req_o;
		end
	end
endmodule : dagm_dec_model

// File: dv/tb.sv
// Purpose: self-checking bench for the address generation unit
// Assumes: zero-wait apb slave, result one cycle after request
// Notes:   expectations come from local functions, package constants, literals and the driven values
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
module tb;
	logic                clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]         paddr = 12'h000;
	logic [31:0]         pwdata = 32'h00000000, prdata, lit_ext, rd;
	logic                pready, pslverr, done, req_valid, go = 1'b0, er;
	dagm_pkg::dagm_req_t cmd = '0, req, q;
	dagm_pkg::dagm_res_t src, dst;
	int                  n_fail = 0, samples_checked = 0;
	logic [15:0]         st_tab [8] = '{16'h0002, 16'h0004, 16'h0006, 16'hfffe,
		16'hfffc, 16'hfffa, 16'h0008, 16'h0000};
	always #25 clk = ~clk;
	dagm_top dut (.sys_clk_i(clk), .resetn_i(resetn), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(4'hf),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .req_valid_i(req_valid),
		.req_i(req), .src_res_o(src), .dst_res_o(dst), .lit_ext_o(lit_ext), .done_o(done));
	dagm_dec_model u_dec (.sys_clk_i(clk), .resetn_i(resetn), .go_i(go), .cmd_i(cmd),
		.req_valid_o(req_valid), .req_o(req));
	// ------------------------------------------------------------
	// expectation functions
	// ------------------------------------------------------------
	function automatic logic [15:0] fix(input logic [15:0] p, s, lo, hi);
		logic [15:0] sum, len;
		logic        pw;
		sum = p + s;
		len = hi - lo + 16'h0002;
		pw  = ((len & (len - 16'h0001)) == 16'h0000);
		if ((!s[15] || pw) && sum > hi) sum = sum - len;
		else if ((s[15] || pw) && sum < lo) sum = sum + len;
		return sum;
	endfunction : fix
	function automatic logic [15:0] rev(input logic [15:0] v);
		for (int i = 0; i < 16; i++) rev[i] = v[15-i];
	endfunction : rev
	function automatic dagm_pkg::dagm_op_t mk(input dagm_pkg::dagm_unit_t u,
		input dagm_pkg::dagm_mode_t m, input logic [3:0] p, input logic [15:0] v, s);
		mk = '{1'b1, u, m, p, v, s};
	endfunction : mk
	// ------------------------------------------------------------
	// bus and request tasks
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic issue(input dagm_pkg::dagm_req_t r);
		@(posedge clk);
		go  <= 1'b1;
		cmd <= r;
		@(posedge clk);
		go  <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("done", 1'b1, done)
	endtask : issue
	task automatic chk_res(input dagm_pkg::dagm_res_t r, input logic [15:0] ea, wv,
		input logic wb, xm, ym);
		`CHK("ea", ea, r.ea)
		`CHK("wb_en", wb, r.wb_en)
		`CHK("wb_val", wv, r.wb_val)
		`CHK("xmod", xm, r.xmod)
		`CHK("ymod", ym, r.ymod)
	endtask : chk_res
	task automatic results;
		if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		results();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] v, e, lo, hi;
		logic [3:0]  p;
		logic        bad, any_bad;
		int          k;
		void'($urandom(32'haf178423));
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, dagm_pkg::OFF_MODE, 32'h0);
		`CHK("mode_rst", {16'h0000, dagm_pkg::MODE_RST}, rd)
		apb(1'b0, dagm_pkg::OFF_XEND, 32'h0);
		`CHK("xend_rst", {16'h0000, dagm_pkg::ADDR_RST}, rd)
		v = 16'($urandom());
		// upper half carries noise that the register must drop
		apb(1'b1, dagm_pkg::OFF_YSTART, {16'($urandom()), v});
		apb(1'b0, dagm_pkg::OFF_YSTART, 32'h0);
		`CHK("ystart_rw", 32'(v), rd)
		apb(1'b1, 12'h01c, 32'h0000ffff);
		`CHK("unmapped_err", 1'b1, er)
		apb(1'b0, 12'h01c, 32'h0);
		`CHK("unmapped_rd", 32'h0, rd)
		apb(1'b1, dagm_pkg::OFF_XSTART, 32'h1000);
		apb(1'b1, dagm_pkg::OFF_XEND, 32'h101e);
		apb(1'b1, dagm_pkg::OFF_YSTART, 32'h2000);
		apb(1'b1, dagm_pkg::OFF_YEND, 32'h200e);
		apb(1'b1, dagm_pkg::OFF_MODE, 32'h8ff1);
		q = '0;
		q.lit_interrupt_disable_instruction = 1'b1;
		q.lit = 16'hffff;
		q.off_val = 16'h0004;
		q.op[0] = mk(dagm_pkg::DAGM_U_XRD, dagm_pkg::DAGM_AM_POST, 4'h1, 16'h101c, 16'h0006);
		q.op[1] = mk(dagm_pkg::DAGM_U_XWR, dagm_pkg::DAGM_AM_REGOFF, 4'h1, 16'h101c, 16'h0);
		issue(q);
		chk_res(src, 16'h101c, fix(16'h101c, 16'h6, 16'h1000, 16'h101e), 1, 1, 0);
		chk_res(dst, 16'h1000, 16'h1000, 0, 1, 0);
		`CHK("lit_interrupt_disable_instruction", 32'h00003fff, lit_ext)
		q.lit_interrupt_disable_instruction = 1'b0;
		q.lit = 16'h8000;
		q.off_val = 16'h0012;
		q.op[0] = mk(dagm_pkg::DAGM_U_XRD, dagm_pkg::DAGM_AM_REGOFF, 4'h1, 16'h1010, 16'h0);
		q.op[1] = mk(dagm_pkg::DAGM_U_XWR, dagm_pkg::DAGM_AM_REGOFF, 4'h3, 16'h0200, 16'h0);
		issue(q);
		chk_res(src, 16'h1002, 16'h1002, 0, 1, 0);
		chk_res(dst, 16'h0212, 16'h0212, 0, 0, 0);
		`CHK("lit_bra", 32'hffff8000, lit_ext)
		for (k = 0; k < 2; k++) begin
			apb(1'b1, dagm_pkg::OFF_MODE, k == 0 ? 32'h8fff : 32'h0ff1);
			p = k == 0 ? 4'hf : 4'h1;
			q.op[0] = mk(dagm_pkg::DAGM_U_XRD, dagm_pkg::DAGM_AM_POST, p, 16'h101c, 16'h6);
			q.op[1] = mk(dagm_pkg::DAGM_U_XWR, dagm_pkg::DAGM_AM_PRE, p, 16'h101c, 16'h6);
			issue(q);
			chk_res(src, 16'h101c, 16'h1022, 1, 0, 0);
			chk_res(dst, 16'h1022, 16'h1022, 1, 0, 0);
		end
		apb(1'b1, dagm_pkg::OFF_MODE, 32'h4f2f);
		q.op[0] = mk(dagm_pkg::DAGM_U_Y, dagm_pkg::DAGM_AM_PRE, 4'h2, 16'h2000, 16'hfffc);
		q.op[1] = mk(dagm_pkg::DAGM_U_Y, dagm_pkg::DAGM_AM_PRE, 4'h2, 16'h2007, 16'h0002);
		issue(q);
		chk_res(src, 16'h200c, 16'h200c, 1, 0, 1);
		chk_res(dst, 16'h2008, 16'h2008, 1, 0, 1);
		apb(1'b1, dagm_pkg::OFF_MODE, 32'h8ff1);
		for (k = 0; k < 2; k++) begin
			hi = k == 0 ? 16'h1016 : 16'h101e;
			apb(1'b1, dagm_pkg::OFF_XEND, 32'(hi));
			q.op[0] = mk(dagm_pkg::DAGM_U_XRD, dagm_pkg::DAGM_AM_PRE, 4'h1, 16'h0ff0, 16'h2);
			q.op[1] = mk(dagm_pkg::DAGM_U_XRD, dagm_pkg::DAGM_AM_PRE, 4'h1, 16'h1000, 16'hfffe);
			issue(q);
			e = fix(16'h0ff0, 16'h2, 16'h1000, hi);
			chk_res(src, e, e, 1, 1, 0);
			e = fix(16'h1000, 16'hfffe, 16'h1000, hi);
			chk_res(dst, e, e, 1, 1, 0);
		end
		apb(1'b1, dagm_pkg::OFF_MODE, 32'hcfb9);
		q.mac = 1'b1;
		q.op[0] = mk(dagm_pkg::DAGM_U_Y, dagm_pkg::DAGM_AM_POST, 4'h9, 16'h101e, 16'h2);
		q.op[1] = mk(dagm_pkg::DAGM_U_XRD, dagm_pkg::DAGM_AM_POST, 4'hb, 16'h200e, 16'h2);
		issue(q);
		chk_res(src, 16'h101e, 16'h1000, 1, 1, 0);
		chk_res(dst, 16'h200e, 16'h2000, 1, 0, 1);
		apb(1'b1, dagm_pkg::OFF_MODE, 32'h82f1);
		apb(1'b1, dagm_pkg::OFF_BREV, 32'h8008);
		q.mac = 1'b0;
		v = 16'($urandom_range(255, 0)) << 4;
		q.op[0] = mk(dagm_pkg::DAGM_U_XWR, dagm_pkg::DAGM_AM_POST, 4'h2, v, 16'h2);
		q.op[1] = mk(dagm_pkg::DAGM_U_XRD, dagm_pkg::DAGM_AM_POST, 4'h2, v, 16'h2);
		issue(q);
		e = rev(rev(v) + rev(16'h0010)) & 16'hfffe;
		`CHK("brev_wb", e, src.wb_val)
		`CHK("brev_xwr", 1'b1, src.brev)
		`CHK("brev_xrd", 1'b0, dst.brev)
		`CHK("xrd_wb", v + 16'h2, dst.wb_val)
		apb(1'b1, dagm_pkg::OFF_BREV, 32'h0);
		apb(1'b1, dagm_pkg::OFF_MODE, 32'(dagm_pkg::MODE_RST));
		apb(1'b1, dagm_pkg::OFF_STAT, 32'h1f);
		any_bad = 1'b0;
		q.mac = 1'b1;
		repeat (60) begin
			q.off_val = $urandom_range(63, 0) << 1;
			for (int j = 0; j < 2; j++) begin
				p = (j == 0) ? 4'($urandom_range(15, 0)) : 4'($urandom_range(11, 8));
				k = $urandom_range(7, 0);
				q.op[j] = mk(dagm_pkg::dagm_unit_t'($urandom_range(2, 0)),
					dagm_pkg::dagm_mode_t'(3'($urandom_range(2, 1)) + 3'(j == 0 && k == 7) * 3'h3),
					p, 16'h0800 + (16'($urandom_range(255, 0)) << 1), st_tab[k]);
			end
			issue(q);
			for (int j = 0; j < 2; j++) begin
				dagm_pkg::dagm_res_t r;
				r = j == 0 ? src : dst;
				p = q.op[j].ptr_sel;
				// literal offset is no mac mode; post steps limited to +-2, +-4, +-6
				bad = p < 4'h8 || p > 4'hb || !(q.op[j].mode inside {dagm_pkg::DAGM_AM_IND,
					dagm_pkg::DAGM_AM_POST, dagm_pkg::DAGM_AM_REGOFF})
					|| (q.op[j].mode == dagm_pkg::DAGM_AM_POST && !(q.op[j].step inside
					{16'h0002, 16'h0004, 16'h0006, 16'hfffe, 16'hfffc, 16'hfffa}))
					|| (q.op[j].mode == dagm_pkg::DAGM_AM_REGOFF && !p[0]);
				any_bad |= bad;
				`CHK("mac_inv", bad, r.invalid)
				e = q.op[j].ptr_val + (q.op[j].mode == dagm_pkg::DAGM_AM_REGOFF ? q.off_val : 16'h0);
				if (!bad) `CHK("mac_ea", e, r.ea)
				`CHK("mac_wb", !bad && q.op[j].mode == dagm_pkg::DAGM_AM_POST, r.wb_en)
			end
		end
		apb(1'b0, dagm_pkg::OFF_STAT, 32'h0);
		`CHK("stat_inv", any_bad, rd[dagm_pkg::ST_MACERR])
		apb(1'b1, dagm_pkg::OFF_STAT, 32'h1f);
		apb(1'b0, dagm_pkg::OFF_STAT, 32'h0);
		`CHK("stat_clr", 32'h0, rd)
		results();
	end
endmodule : tb

// File: include/dagm_pkg.sv
// Purpose: shared constants and types of the address generation unit
// Assumes: 16-bit data space, word registers on a 32-bit APB
// Notes:   register offsets are byte addresses
package dagm_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [11:0] OFF_MODE   = 12'h000;
	localparam logic [11:0] OFF_XSTART = 12'h004;
	localparam logic [11:0] OFF_XEND   = 12'h008;
	localparam logic [11:0] OFF_YSTART = 12'h00c;
	localparam logic [11:0] OFF_YEND   = 12'h010;
	localparam logic [11:0] OFF_BREV   = 12'h014;
	localparam logic [11:0] OFF_STAT   = 12'h018;
	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int          XSEL_LSB   = 0;
	localparam int          YSEL_LSB   = 4;
	localparam int          BSEL_LSB   = 8;
	localparam int          XEN_BIT    = 15;
	localparam int          YEN_BIT    = 14;
	localparam int          BREN_BIT   = 15;
	localparam int          ST_XMOD    = 0;
	localparam int          ST_YMOD    = 1;
	localparam int          ST_BREV    = 2;
	localparam int          ST_MACERR  = 3;
	localparam int          ST_CFGERR  = 4;
	localparam int          INTERRUPT_DISABLE_INSTRUCTION_W     = 14;
	localparam logic [3:0]  SEL_NONE   = 4'hf;
	localparam logic [1:0]  MAC_GRP    = 2'h2;
	localparam logic [15:0] MODE_RST   = 16'h0fff;
	localparam logic [15:0] ADDR_RST   = 16'h0000;
	localparam logic [15:0] BREV_RST   = 16'h0000;
	localparam logic [15:0] STEP2      = 16'h0002;
	localparam logic [15:0] STEP4      = 16'h0004;
	localparam logic [15:0] STEP6      = 16'h0006;
	localparam logic [15:0] WORD_ADJ   = 16'h0002;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DAGM_AM_DIRECT, DAGM_AM_IND, DAGM_AM_POST,
		DAGM_AM_PRE, DAGM_AM_REGOFF, DAGM_AM_LITOFF
	} dagm_mode_t;
	typedef enum logic [1:0] {DAGM_U_XRD, DAGM_U_XWR, DAGM_U_Y} dagm_unit_t;
	typedef struct packed {
		logic        valid;
		dagm_unit_t  unit;
		dagm_mode_t  mode;
		logic [3:0]  ptr_sel;
		logic [15:0] ptr_val;
		logic [15:0] step;
	} dagm_op_t;
	typedef struct packed {
		logic            mac;
		logic            byte_acc;
		logic            lit_interrupt_disable_instruction;
		logic [15:0]     lit;
		logic [15:0]     off_val;
		dagm_op_t [1:0]  op;
	} dagm_req_t;
	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] xstart;
		logic [15:0] xend;
		logic [15:0] ystart;
		logic [15:0] yend;
		logic [15:0] brev;
	} dagm_cfg_t;
	typedef struct packed {
		logic [15:0] ea;
		logic        wb_en;
		logic [15:0] wb_val;
		logic        invalid;
		logic        xmod;
		logic        ymod;
		logic        brev;
	} dagm_res_t;
	typedef struct packed {
		dagm_cfg_t   cfg;
		logic [4:0]  stat;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		dagm_res_t   src;
		dagm_res_t   dst;
		logic [31:0] lit;
		logic        done;
	} dagm_state_t;
endpackage : dagm_pkg
